// [rtl/bits_debounce.sv]
// input synchroniser and debounce filter with edge pulses
`default_nettype none

module bits_debounce (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        pin_in,
	input  wire logic        ms_tick,
	input  wire logic [13:0] stable_ms,
	output logic             level,
	output logic             rise,
	output logic             fall
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic        s1;
		logic        s2;
		logic        lvl;
		logic [13:0] cnt;
		logic        rise;
		logic        fall;
	} bits_deb_st_t;

	bits_deb_st_t q, d;

	// candidate level must hold a full interval before it is accepted
	always_comb begin
		d = q;
		d.s1 = pin_in;
		d.s2 = q.s1;
		d.rise = 1'b0;
		d.fall = 1'b0;
		if (q.s2 == q.lvl) begin
			d.cnt = 14'h0000;
		end else if (ms_tick) begin
			if (q.cnt + 14'h0001 >= stable_ms) begin
				d.lvl = q.s2;
				d.cnt = 14'h0000;
				d.rise = q.s2; // one pulse per accepted change
				d.fall = ~q.s2;
			end else begin
				d.cnt = q.cnt + 14'h0001;
			end
		end
	end

	// register the state
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign level = q.lvl;
	assign rise  = q.rise;
	assign fall  = q.fall;

endmodule

`default_nettype wire

// [rtl/bits_pkg.sv]
// constants, field layouts and enumerations of the binary input telegram sender
`default_nettype none

package bits_pkg;

	// ------------------------------------------------------------------
	// time base
	// ------------------------------------------------------------------
	localparam int CLK_HZ    = 40_000_000;
	localparam int TICK_MS   = 1;
	localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int MS_PER_S  = 1000;
	localparam int MS_PER_MIN = 60_000;
	localparam int REST_D5_S  = 5;
	localparam int REST_D10_S = 10;
	localparam int REST_D15_S = 15;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [4:0] OFS_CFG    = 5'h00;
	localparam logic [4:0] OFS_VRISE  = 5'h04;
	localparam logic [4:0] OFS_VFALL  = 5'h08;
	localparam logic [4:0] OFS_BLOCK  = 5'h0c;
	localparam logic [4:0] OFS_STATUS = 5'h10;

	// ------------------------------------------------------------------
	// enumerations
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		OBJ_SWITCH = 3'h0,
		OBJ_PRIO   = 3'h1,
		OBJ_U8     = 3'h2,
		OBJ_PCT    = 3'h3,
		OBJ_F16    = 3'h4,
		OBJ_F32    = 3'h5
	} bits_obj_t;

	typedef enum logic [1:0] {
		CYC_NEVER  = 2'h0,
		CYC_ALWAYS = 2'h1,
		CYC_HIGH   = 2'h2,
		CYC_LOW    = 2'h3
	} bits_cyc_t;

	typedef enum logic [2:0] {
		REST_NONE = 3'h0,
		REST_IMM  = 3'h1,
		REST_D5   = 3'h2,
		REST_D10  = 3'h3,
		REST_D15  = 3'h4
	} bits_rest_t;

	typedef enum logic [1:0] {
		BSET_IGNORE = 2'h0,
		BSET_NONE   = 2'h1,
		BSET_RISE   = 2'h2,
		BSET_FALL   = 2'h3
	} bits_bset_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} bits_tx_t;

	// ------------------------------------------------------------------
	// configuration word layout
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [5:0] cyc_min;
		logic [2:0] deb_sel;
		logic       blk_pol;
		logic       blk_en;
		logic       rel_upd;
		bits_bset_t bset;
		bits_rest_t rest;
		bits_cyc_t  cyc;
		logic       send_fall;
		logic       send_rise;
		bits_obj_t  otype;
	} bits_cfg_t;

	localparam logic [23:0] CFG_RESET = 24'h048008;

	// telegram setting codes held in the low bits of a value word
	localparam logic [1:0] SW_OFF     = 2'h0;
	localparam logic [1:0] SW_ON      = 2'h1;
	localparam logic [1:0] SW_TOGGLE  = 2'h2;
	localparam logic [1:0] PR_INACT   = 2'h0;
	localparam logic [1:0] PR_ON      = 2'h1;
	localparam logic [1:0] PR_OFF     = 2'h2;
	localparam logic [1:0] PR_ENC_INA = 2'h0;
	localparam logic [1:0] PR_ENC_ON  = 2'h3;
	localparam logic [1:0] PR_ENC_OFF = 2'h2;
	localparam logic [7:0] PCT_MAX    = 8'h64;

	// queue entry codes
	localparam logic [1:0] Q_NONE = 2'h0;
	localparam logic [1:0] Q_RISE = 2'h1;
	localparam logic [1:0] Q_FALL = 2'h2;
	localparam logic [1:0] Q_UPD  = 2'h3;
	localparam int         QD     = 4;

	// debounce interval in ms for each selection
	function automatic logic [13:0] deb_ms(input logic [2:0] sel);
		case (sel)
			3'h0: deb_ms = 14'd30;
			3'h1: deb_ms = 14'd50;
			3'h2: deb_ms = 14'd80;
			3'h3: deb_ms = 14'd100;
			3'h4: deb_ms = 14'd200;
			3'h5: deb_ms = 14'd1000;
			3'h6: deb_ms = 14'd5000;
			default: deb_ms = 14'd10000;
		endcase
	endfunction

endpackage

`default_nettype wire

// [rtl/bits_sender.sv]
// binary input channel object: edge, cyclic, restore and block telegrams
`default_nettype none

module bits_sender #(
	parameter int MS_CYCLES = bits_pkg::MS_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        contact_in,
	input  wire logic        bus_restored,
	output logic             tx_valid,
	input  wire logic        tx_ready,
	output logic [2:0]       tx_type,
	output logic [31:0]      tx_data
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [23:0]                 cfg;
		logic [31:0]                 vrise;
		logic [31:0]                 vfall;
		logic                        blk_obj;
		logic                        rd_ack;
		logic [31:0]                 rdata;
		logic [15:0]                 ms_cnt;
		logic [21:0]                 cyc_cnt;
		logic [13:0]                 rst_cnt;
		logic                        rst_arm;
		logic                        sw_state;
		logic                        blk_prev;
		logic [bits_pkg::QD-1:0][1:0] que;
		logic [2:0]                  qn;
		bits_pkg::bits_tx_t          tx_st;
		logic [2:0]                  tx_type;
		logic [31:0]                 tx_data;
	} bits_st_t;

	bits_st_t           q, d;
	bits_pkg::bits_cfg_t cfg;
	logic               ms_tick;
	logic               in_level;
	logic               in_rise;
	logic               in_fall;
	logic               blocked;
	logic               ignore_blk;
	logic               eff_blk;
	logic               cyc_req;
	logic               rest_req;
	logic [1:0]         req;
	logic [1:0]         head;
	logic [31:0]        word;
	logic [31:0]        sel_val;

	assign cfg = bits_pkg::bits_cfg_t'(q.cfg);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------

	// merge write data into a word under byte enables
	function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// shape a configured value word into the telegram payload of the object type
	function automatic logic [31:0] fmt(input bits_pkg::bits_obj_t t, input logic [31:0] v,
		input logic sw);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (t)
			bits_pkg::OBJ_SWITCH: begin
				unique case (v[1:0])
					bits_pkg::SW_ON:     r[0] = 1'b1;
					bits_pkg::SW_TOGGLE: r[0] = ~sw;
					default:             r[0] = 1'b0;
				endcase
			end
			bits_pkg::OBJ_PRIO: begin
				unique case (v[1:0])
					bits_pkg::PR_ON:  r[1:0] = bits_pkg::PR_ENC_ON;
					bits_pkg::PR_OFF: r[1:0] = bits_pkg::PR_ENC_OFF;
					default:          r[1:0] = bits_pkg::PR_ENC_INA;
				endcase
			end
			bits_pkg::OBJ_U8: r[7:0] = v[7:0];
			bits_pkg::OBJ_PCT: begin
				r[7:0] = (v[7:0] > bits_pkg::PCT_MAX) ? bits_pkg::PCT_MAX : v[7:0];
			end
			bits_pkg::OBJ_F16: r[15:0] = v[15:0];
			default:           r = v;
		endcase
		return r;
	endfunction

	// cycle period in ms, a zero setting counts as one minute
	function automatic logic [21:0] cyc_ms(input logic [5:0] mins);
		logic [5:0] m;
		m = (mins == 6'h00) ? 6'h01 : mins;
		return 22'(int'(m) * bits_pkg::MS_PER_MIN);
	endfunction

	// ------------------------------------------------------------------
	// input filter
	// ------------------------------------------------------------------
	bits_debounce u_deb (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.pin_in    (contact_in),
		.ms_tick   (ms_tick),
		.stable_ms (bits_pkg::deb_ms(cfg.deb_sel)),
		.level     (in_level),
		.rise      (in_rise),
		.fall      (in_fall)
	);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		word = 32'h0000_0000;
		sel_val = 32'h0000_0000;
		cyc_req = 1'b0;
		rest_req = 1'b0;
		req = bits_pkg::Q_NONE;
		head = q.que[0];

		// block state from the block object and polarity
		blocked = cfg.blk_en & (q.blk_obj ^ cfg.blk_pol);
		ignore_blk = (cfg.bset == bits_pkg::BSET_IGNORE);
		eff_blk = blocked & ~ignore_blk;
		// edge detector on the block state; a config write may start or end a block too
		d.blk_prev = blocked;

		// millisecond time base
		// every interval of the block is counted in these ticks, never in raw cycles
		ms_tick = (q.ms_cnt == 16'(MS_CYCLES - 1));
		d.ms_cnt = ms_tick ? 16'h0000 : q.ms_cnt + 16'h0001;

		// bus slave: reads take one wait state, writes none
		// every address answers; unmapped ones read as zero
		d.rd_ack = avs_read & ~q.rd_ack;
		if (avs_read && !q.rd_ack) begin
			unique case (avs_address)
				bits_pkg::OFS_CFG:    d.rdata = {8'h00, q.cfg};
				bits_pkg::OFS_VRISE:  d.rdata = q.vrise;
				bits_pkg::OFS_VFALL:  d.rdata = q.vfall;
				bits_pkg::OFS_BLOCK:  d.rdata = {31'h0000_0000, q.blk_obj};
				bits_pkg::OFS_STATUS: d.rdata = {28'h000_0000, (q.qn != 3'h0), q.sw_state,
					blocked, in_level};
				default:              d.rdata = 32'h0000_0000;
			endcase
		end
		if (avs_write) begin
			unique case (avs_address)
				bits_pkg::OFS_CFG: begin
					word = apply_be({8'h00, q.cfg}, avs_writedata, avs_byteenable);
					d.cfg = word[23:0];
				end
				bits_pkg::OFS_VRISE: d.vrise = apply_be(q.vrise, avs_writedata, avs_byteenable);
				bits_pkg::OFS_VFALL: d.vfall = apply_be(q.vfall, avs_writedata, avs_byteenable);
				bits_pkg::OFS_BLOCK: begin
					if (avs_byteenable[0]) begin
						d.blk_obj = avs_writedata[0];
					end
				end
				default: begin
				end
			endcase
		end

		// cyclic repetition on the shared period
		// the counter runs free, so the first period after a mode change may be short
		if (ms_tick) begin
			if (q.cyc_cnt + 22'h00_0001 >= cyc_ms(cfg.cyc_min)) begin
				d.cyc_cnt = 22'h00_0000;
				unique case (cfg.cyc)
					bits_pkg::CYC_ALWAYS: cyc_req = ~blocked;
					bits_pkg::CYC_HIGH:   cyc_req = ~blocked & in_level;
					bits_pkg::CYC_LOW:    cyc_req = ~blocked & ~in_level;
					default:              cyc_req = 1'b0;
				endcase
			end else begin
				d.cyc_cnt = q.cyc_cnt + 22'h00_0001;
			end
		end

		// response after the bus supply returns
		if (bus_restored) begin
			unique case (cfg.rest)
				bits_pkg::REST_IMM: begin
					rest_req = 1'b1;
					d.rst_arm = 1'b0; // a fresh return cancels a pending delayed update
				end
				bits_pkg::REST_D5: begin
					d.rst_cnt = 14'(bits_pkg::REST_D5_S * bits_pkg::MS_PER_S);
					d.rst_arm = 1'b1;
				end
				bits_pkg::REST_D10: begin
					d.rst_cnt = 14'(bits_pkg::REST_D10_S * bits_pkg::MS_PER_S);
					d.rst_arm = 1'b1;
				end
				bits_pkg::REST_D15: begin
					d.rst_cnt = 14'(bits_pkg::REST_D15_S * bits_pkg::MS_PER_S);
					d.rst_arm = 1'b1;
				end
				default: d.rst_arm = 1'b0;
			endcase
		end else if (q.rst_arm && ms_tick) begin
			if (q.rst_cnt <= 14'h0001) begin
				rest_req = 1'b1;
				d.rst_arm = 1'b0;
			end else begin
				d.rst_cnt = q.rst_cnt - 14'h0001;
			end
		end

		// choose the one request of this cycle
		// block transitions outrank input edges; a lower request in the same cycle is lost
		if (blocked && !q.blk_prev && !ignore_blk) begin
			if (cfg.bset == bits_pkg::BSET_RISE) begin
				req = bits_pkg::Q_RISE;
			end else if (cfg.bset == bits_pkg::BSET_FALL) begin
				req = bits_pkg::Q_FALL;
			end
		end else if (!blocked && q.blk_prev && !ignore_blk) begin
			if (cfg.rel_upd) begin
				req = bits_pkg::Q_UPD;
			end
		end else if (in_rise && cfg.send_rise && !eff_blk) begin
			req = bits_pkg::Q_RISE;
		end else if (in_fall && cfg.send_fall && !eff_blk) begin
			req = bits_pkg::Q_FALL;
		end else if (rest_req && !eff_blk) begin
			req = bits_pkg::Q_UPD;
		end else if (cyc_req) begin
			req = bits_pkg::Q_UPD;
		end

		// telegram output: take the queue head when idle
		unique case (q.tx_st)
			bits_pkg::TX_IDLE: begin
				if (q.qn != 3'h0) begin
					unique case (head)
						bits_pkg::Q_RISE: sel_val = q.vrise;
						bits_pkg::Q_FALL: sel_val = q.vfall;
						default:          sel_val = in_level ? q.vrise : q.vfall;
					endcase
					// type and payload are frozen here and stand until taken
					d.tx_type = cfg.otype;
					d.tx_data = fmt(cfg.otype, sel_val, q.sw_state);
					// a toggle reads the object state as it was before this telegram
					if (cfg.otype == bits_pkg::OBJ_SWITCH) begin
						d.sw_state = d.tx_data[0];
					end
					for (int i = 0; i < bits_pkg::QD - 1; i++) begin
						d.que[i] = q.que[i+1];
					end
					d.que[bits_pkg::QD-1] = bits_pkg::Q_NONE;
					d.qn = q.qn - 3'h1;
					d.tx_st = bits_pkg::TX_SEND;
				end
			end
			bits_pkg::TX_SEND: begin
				if (tx_ready) begin
					d.tx_st = bits_pkg::TX_IDLE;
				end
			end
		endcase

		// append the new request behind older ones
		// a full queue drops the request, so the input filter never has to stall
		if (req != bits_pkg::Q_NONE && d.qn < 3'(bits_pkg::QD)) begin
			d.que[d.qn[1:0]] = req;
			d.qn = d.qn + 3'h1;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------

	// register the whole state
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			q <= '0;
			q.cfg <= bits_pkg::CFG_RESET;
		end else begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------

	// bus answer and telegram port
	// waitrequest is combinational so every read sees exactly one wait state
	assign avs_waitrequest = avs_read & ~q.rd_ack;
	assign avs_readdata    = q.rdata;
	assign tx_valid        = (q.tx_st == bits_pkg::TX_SEND);
	assign tx_type         = q.tx_type;
	assign tx_data         = q.tx_data;

endmodule

`default_nettype wire

// [test/bits_bus_sink.sv]
// telegram receiver on the far side of the sender, with adjustable stall
`default_nettype none

module bits_bus_sink (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        tx_valid,
	output var logic         tx_ready,
	input  wire logic [2:0]  tx_type,
	input  wire logic [31:0] tx_data,
	input  wire logic [3:0]  stall
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [34:0] rx_q[$];  // telegrams taken, oldest first
	logic [3:0]  wait_q;   // cycles stalled so far

	// take a telegram once the programmed stall has passed
	always @(posedge sys_clk) begin
		if (!rstn) begin
			tx_ready <= 1'b0;
			wait_q   <= 4'h0;
		end else if (tx_valid && tx_ready) begin
			rx_q.push_back({tx_type, tx_data});
			tx_ready <= 1'b0;
			wait_q   <= 4'h0;
		end else if (tx_valid) begin
			if (wait_q >= stall) begin
				tx_ready <= 1'b1;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule

`default_nettype wire

// [test/bits_sender_chk.sv]
// concurrent checks on the register bus and telegram port of the sender
`default_nettype none

module bits_sender_chk #(
	parameter int MS_CYCLES = 4
) (
	input wire logic        sys_clk,
	input wire logic        rstn,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest,
	input wire logic        tx_valid,
	input wire logic        tx_ready,
	input wire logic [2:0]  tx_type,
	input wire logic [31:0] tx_data
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	// reads wait exactly one cycle, writes never wait
	AST_RD_WAIT: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read not answered after one wait cycle");
	AST_WR_NOWAIT: assert property (avs_write |-> !avs_waitrequest)
		else $error("write stalled");
	// offered telegram stands until taken, then a gap
	AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_data) && $stable(tx_type))
		else $error("telegram changed before it was taken");
	AST_TX_GAP: assert property (tx_valid && tx_ready |=> !tx_valid)
		else $error("telegram offered again in the cycle after a take");
	// object type range and payload encodings per object type
	AST_TYPE_OK: assert property (tx_valid |-> tx_type <= bits_pkg::OBJ_F32)
		else $error("unknown object type offered");
	AST_PCT_MAX: assert property (tx_valid && tx_type == bits_pkg::OBJ_PCT |->
		tx_data[7:0] <= bits_pkg::PCT_MAX)
		else $error("percentage above full scale");
	AST_PRIO_ENC: assert property (tx_valid && tx_type == bits_pkg::OBJ_PRIO |->
		tx_data[1:0] != 2'h1)
		else $error("priority code 01 offered");
	AST_SW_BIT: assert property (tx_valid && tx_type == bits_pkg::OBJ_SWITCH |->
		tx_data[1] == 1'b0)
		else $error("switch payload wider than one bit");

	// main scenarios
	cover property (tx_valid && !tx_ready ##1 tx_valid && tx_ready);
	cover property (avs_read && !avs_waitrequest);
	cover property (tx_valid && tx_type == bits_pkg::OBJ_PRIO);
endmodule

bind bits_sender bits_sender_chk #(.MS_CYCLES(MS_CYCLES)) u_chk (
	.sys_clk(sys_clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .tx_valid(tx_valid), .tx_ready(tx_ready),
	.tx_type(tx_type), .tx_data(tx_data));

`default_nettype wire

// [test/bits_sender_tb.sv]
// self-checking bench for the binary input telegram sender
`default_nettype none

module bits_sender_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int MS = 1;  // one cycle per ms tick, so a one-minute cycle fits the run

	logic        sys_clk;
	logic        rstn;
	logic [4:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        contact_in;
	logic        bus_restored;
	logic        tx_valid;
	logic        tx_ready;
	logic [2:0]  tx_type;
	logic [31:0] tx_data;
	logic [3:0]  stall;
	int          mismatches;
	int          n_tests;

	bits_sender #(.MS_CYCLES(MS)) dut (
		.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .contact_in(contact_in),
		.bus_restored(bus_restored), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_type(tx_type), .tx_data(tx_data));

	bits_bus_sink u_sink (
		.sys_clk(sys_clk), .rstn(rstn), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_type(tx_type), .tx_data(tx_data), .stall(stall));

	// ----------------------------------------
	// clock, tasks and verdict
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic bus_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be = 4'hf);
		@(posedge sys_clk);
		avs_address    <= a;
		avs_writedata  <= d;
		avs_byteenable <= be;
		avs_write      <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		avs_write <= 1'b0;
	endtask

	task automatic check_reg(input logic [4:0] a, input logic [31:0] exp,
		input logic [31:0] m = 32'hffff_ffff);
		logic [31:0] d;
		@(posedge sys_clk);
		avs_address <= a;
		avs_read    <= 1'b1;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		d = avs_readdata;
		avs_read <= 1'b0;
		cmp(d & m, exp, "register");
	endtask

	task automatic expect_tx(input logic [2:0] t, input logic [31:0] d, input logic [31:0] m,
		input int lim);
		logic [34:0] e;
		repeat (lim) if (u_sink.rx_q.size() == 0) @(posedge sys_clk);
		e = (u_sink.rx_q.size() != 0) ? u_sink.rx_q.pop_front() : 35'h7_ffff_ffff;
		cmp({29'h0, e[34:32]}, {29'h0, t}, "telegram type");
		cmp(e[31:0] & m, d, "telegram data");
	endtask

	task automatic expect_quiet(input int n);
		repeat (n) @(posedge sys_clk);
		cmp(32'(u_sink.rx_q.size()), 32'h0, "unexpected telegram");
	endtask

	task automatic pin(input logic v);
		@(posedge sys_clk);
		contact_in <= v;
	endtask

	task automatic restore_pulse();
		@(posedge sys_clk);
		bus_restored <= 1'b1;
		@(posedge sys_clk);
		bus_restored <= 1'b0;
	endtask

	// config word: type, {fall, rise}, restore, block-set, {polarity, enable, release}
	function automatic logic [31:0] cfg(input logic [2:0] ty, input logic [1:0] ed,
		input logic [2:0] rs, input logic [1:0] bs, input logic [2:0] bk);
		cfg = {8'h0, 6'h01, 3'h0, bk, bs, rs, 2'h0, ed, ty};
	endfunction

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (90000) @(posedge sys_clk);
		mismatches++;
		$display("ERROR %0t watchdog expired", $time);
		conclude();
	end

	// value tables: type, written value, expected payload, payload mask
	localparam logic [2:0]  VT [4] = '{bits_pkg::OBJ_U8, bits_pkg::OBJ_PCT, bits_pkg::OBJ_F16,
		bits_pkg::OBJ_F32};
	localparam logic [31:0] VV [4] = '{32'hff, 32'hc8, 32'h1234_abcd, 32'hdead_beef};
	localparam logic [31:0] VE [4] = '{32'hff, 32'h64, 32'habcd, 32'hdead_beef};
	localparam logic [31:0] VM [4] = '{32'hff, 32'hff, 32'hffff, 32'hffff_ffff};
	localparam logic [2:0]  ST [3] = '{bits_pkg::OBJ_SWITCH, bits_pkg::OBJ_SWITCH,
		bits_pkg::OBJ_PRIO};
	localparam logic [1:0]  SR [3] = '{2'h1, 2'h2, 2'h1};
	localparam logic [1:0]  SF [3] = '{2'h0, 2'h2, 2'h2};
	localparam logic [1:0]  ER [3] = '{2'h1, 2'h1, 2'h3};
	localparam logic [1:0]  EF [3] = '{2'h0, 2'h0, 2'h2};

	initial begin
		rstn = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		contact_in = 1'b0;
		bus_restored = 1'b0;
		stall = 4'h0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		check_reg(bits_pkg::OFS_CFG, 32'h0004_8008);
		check_reg(bits_pkg::OFS_VRISE, 32'h0);
		check_reg(5'h14, 32'h0);
		bus_wr(bits_pkg::OFS_STATUS, 32'hffff_ffff);
		check_reg(bits_pkg::OFS_STATUS, 32'h0);
		bus_wr(bits_pkg::OFS_VRISE, 32'h1122_3344, 4'h3);
		check_reg(bits_pkg::OFS_VRISE, 32'h3344);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			bus_wr(bits_pkg::OFS_CFG, cfg(VT[i], 2'h1, bits_pkg::REST_NONE, 2'h0, 3'h0));
			bus_wr(bits_pkg::OFS_VRISE, VV[i]);
			pin(1'b1);
			expect_quiet(25);
			expect_tx(VT[i], VE[i], VM[i], 300);
			pin(1'b0);
			expect_quiet(300);
		end
		$display("test value types done");
		for (int i = 0; i < 3; i++) begin
			bus_wr(bits_pkg::OFS_CFG, cfg(ST[i], 2'h3, bits_pkg::REST_NONE, 2'h0, 3'h0));
			bus_wr(bits_pkg::OFS_VRISE, {30'h0, SR[i]});
			bus_wr(bits_pkg::OFS_VFALL, {30'h0, SF[i]});
			pin(1'b1);
			expect_tx(ST[i], {30'h0, ER[i]}, 32'h3, 300);
			pin(1'b0);
			expect_tx(ST[i], {30'h0, EF[i]}, 32'h3, 300);
		end
		$display("test switch and priority done");
		stall <= 4'h5;
		bus_wr(bits_pkg::OFS_VRISE, 32'h5a);
		bus_wr(bits_pkg::OFS_VFALL, 32'ha5);
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h3, 3'h0, bits_pkg::BSET_RISE, 3'h3));
		bus_wr(bits_pkg::OFS_BLOCK, 32'h1);
		bus_wr(bits_pkg::OFS_BLOCK, 32'h0);
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 50);
		expect_tx(bits_pkg::OBJ_U8, 32'ha5, 32'hff, 50);
		bus_wr(bits_pkg::OFS_BLOCK, 32'h1);
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 50);
		pin(1'b1);
		expect_quiet(300);
		check_reg(bits_pkg::OFS_STATUS, 32'h3, 32'h3);
		bus_wr(bits_pkg::OFS_BLOCK, 32'h0);
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 50);
		stall <= 4'h0;
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h3, 3'h0, bits_pkg::BSET_NONE, 3'h6));
		check_reg(bits_pkg::OFS_STATUS, 32'h2, 32'h2);
		pin(1'b0);
		expect_quiet(300);
		bus_wr(bits_pkg::OFS_BLOCK, 32'h1);
		check_reg(bits_pkg::OFS_STATUS, 32'h0, 32'h2);
		expect_quiet(50);
		bus_wr(bits_pkg::OFS_BLOCK, 32'h0);
		expect_quiet(50);
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h3, 3'h0, 2'h0, 3'h6));
		pin(1'b1);
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 300);
		$display("test block done");
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h3, bits_pkg::REST_IMM, 2'h0, 3'h0));
		restore_pulse();
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 20);
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h3, bits_pkg::REST_D5, 2'h0, 3'h0));
		restore_pulse();
		expect_quiet(bits_pkg::REST_D5_S * bits_pkg::MS_PER_S * MS - 20);
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 100);
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h3, bits_pkg::REST_NONE, 2'h0, 3'h0));
		restore_pulse();
		expect_quiet(300);
		$display("test restore done");
		bus_wr(bits_pkg::OFS_CFG, cfg(bits_pkg::OBJ_U8, 2'h0, bits_pkg::REST_NONE, 2'h0, 3'h0)
			| {25'h0, bits_pkg::CYC_HIGH, 5'h00});
		expect_tx(bits_pkg::OBJ_U8, 32'h5a, 32'hff, 60100);
		$display("test cyclic done");
		conclude();
	end
endmodule

`default_nettype wire
